// >>> ferx_line_model.sv
`timescale 1ns/1ns
// ==========================================
// Far-end transmitter: scrambler, NRZI and three-level coder.
// ==========================================
module ferx_line_model (
    input wire logic mclk,
    input wire logic ce,
    input wire logic plain_bit,
    input wire logic scr_on,
    output logic [1:0] sym_lvl
);
    logic [10:0] lfsr_r = 11'h2b5;
    logic [1:0] ph_r = 2'h0;
    logic key;
    logic sd;
    // Key of a closed-loop LFSR, taps 10 and 8; the seed is arbitrary.
    assign key = lfsr_r[10] ^ lfsr_r[8];
    assign sd = scr_on ? plain_bit ^ key : plain_bit;
    // Bits are consumed on the falling edge so the receiver sees settled levels.
    // The enable is read before the bench updates it, so a frozen receiver skips
    // no symbol and the scrambler stays in step with the descrambler.
    always @(negedge mclk) begin
        if (ce) begin
            lfsr_r <= {lfsr_r[9:0], key};
            ph_r <= ph_r + 2'(sd);
        end
    end
    // Each one steps the wire through zero, plus, zero, minus.
    assign sym_lvl = ph_r[0] ? (ph_r[1] ? ferx_pkg::LVL_NEG : ferx_pkg::LVL_POS) : 2'h0;
endmodule : ferx_line_model

// >>> ferx_pkg.sv
package ferx_pkg;

    // ==========================================================
    // Line symbol encoding of the three-level input.
    // ==========================================================
    localparam logic [1:0] LVL_ZERO = 2'h0;
    localparam logic [1:0] LVL_POS = 2'h1;
    localparam logic [1:0] LVL_NEG = 2'h3;

    // ==========================================================
    // Signal qualification.
    // ==========================================================
    // Link pulses last about 100 ns, roughly a dozen bit times, so a run of 24
    // bit times of continuous energy is needed before signal is reported.
    localparam int SD_QUAL_BITS = 24;
    localparam int SD_CNT_W = 5;

    // ==========================================================
    // Descrambler and hold timer.
    // ==========================================================
    localparam int LFSR_W = 11;
    localparam int LFSR_TAP_HI = 10;
    localparam int LFSR_TAP_LO = 8;
    localparam int GROUP_W = 5;
    localparam int LOCK_IDLE_GROUPS = 12;
    localparam int LOCK_BITS = LOCK_IDLE_GROUPS * GROUP_W;
    localparam int ACQ_CNT_W = 6;
    localparam int IDLE_RUN_BITS = 58;
    localparam int RUN_CNT_W = 6;
    localparam int HOLD_TIME_US = 722;
    localparam int CLK_MHZ = 10;
    localparam int HOLD_CYCLES = HOLD_TIME_US * CLK_MHZ;
    localparam int HOLD_W = 13;

    // ==========================================================
    // Code-groups and nibbles.
    // ==========================================================
    localparam logic [4:0] CG_IDLE = 5'h1f;
    localparam logic [4:0] CG_J = 5'h18;
    localparam logic [4:0] CG_K = 5'h11;
    localparam logic [4:0] CG_T = 5'h0d;
    localparam logic [4:0] CG_R = 5'h07;
    localparam logic [9:0] CG_IDLE_PAIR = {CG_IDLE, CG_IDLE};
    localparam logic [9:0] CG_JK_PAIR = {CG_J, CG_K};
    localparam logic [3:0] NIB_PREAMBLE = 4'h5;
    localparam logic [3:0] NIB_ERROR = 4'he;
    localparam logic [2:0] LAST_PHASE = 3'h4;
    localparam int SR_W = 20;

    typedef enum logic [0:0] {
        FR_HUNT = 1'b0,
        FR_DATA = 1'b1
    } ferx_fr_t;

endpackage : ferx_pkg

// >>> ferx_rx_pcs.sv
`timescale 1ns/1ns

module ferx_rx_pcs #(
    parameter int HOLD_CYCLES = ferx_pkg::HOLD_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [1:0] sym_lvl,
    input wire logic energy_det,
    input wire logic desc_bypass,
    output logic sig_det,
    output logic desc_lock,
    output logic aligned,
    output logic nib_stb,
    output logic rx_dv,
    output logic rx_er,
    output logic [3:0] rxd
);

    // ==========================================================
    // Functions.
    // ==========================================================
    // Returns {is_data, nibble}; control and invalid groups give is_data low.
    function automatic logic [4:0] ferx_decode(input logic [4:0] cg);
        logic [4:0] res;
        res = {1'b0, ferx_pkg::NIB_ERROR};
        case (cg)
            5'h1e: res = 5'h10;
            5'h09: res = 5'h11;
            5'h14: res = 5'h12;
            5'h15: res = 5'h13;
            5'h0a: res = 5'h14;
            5'h0b: res = 5'h15;
            5'h0e: res = 5'h16;
            5'h0f: res = 5'h17;
            5'h12: res = 5'h18;
            5'h13: res = 5'h19;
            5'h16: res = 5'h1a;
            5'h17: res = 5'h1b;
            5'h1a: res = 5'h1c;
            5'h1b: res = 5'h1d;
            5'h1c: res = 5'h1e;
            5'h1d: res = 5'h1f;
            default: res = {1'b0, ferx_pkg::NIB_ERROR};
        endcase
        return res;
    endfunction : ferx_decode

    function automatic logic ferx_key(input logic [ferx_pkg::LFSR_W-1:0] s);
        return s[ferx_pkg::LFSR_TAP_HI] ^ s[ferx_pkg::LFSR_TAP_LO];
    endfunction : ferx_key

    // ==========================================================
    // Front end: signal detect, MLT-3 to NRZI, NRZI to NRZ.
    // ==========================================================
    logic [ferx_pkg::SD_CNT_W-1:0] sd_cnt_r, sd_cnt_nxt;
    logic sig_det_r, sig_det_nxt;
    logic [1:0] lvl_r, lvl_nxt;
    logic nrzi_r, nrzi_nxt;
    logic nrz;

    // Energy must persist for many bit times, so link pulse bursts never qualify.
    always_comb begin
        sd_cnt_nxt = sd_cnt_r;
        sig_det_nxt = sig_det_r;
        if (!energy_det) begin
            sd_cnt_nxt = '0;
            sig_det_nxt = 1'b0;
        end else if (sd_cnt_r == ferx_pkg::SD_CNT_W'(ferx_pkg::SD_QUAL_BITS - 1)) begin
            sig_det_nxt = 1'b1;
        end else begin
            sd_cnt_nxt = sd_cnt_r + 1'b1;
        end
        lvl_nxt = sym_lvl;
        nrzi_nxt = nrzi_r ^ (sym_lvl != lvl_r);
    end

    // A change of NRZI level between bits is a one.
    assign nrz = nrzi_nxt ^ nrzi_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sd_cnt_r <= '0;
            sig_det_r <= 1'b0;
            lvl_r <= ferx_pkg::LVL_ZERO;
            nrzi_r <= 1'b0;
        end else if (ce) begin
            sd_cnt_r <= sd_cnt_nxt;
            sig_det_r <= sig_det_nxt;
            lvl_r <= lvl_nxt;
            nrzi_r <= nrzi_nxt;
        end
    end

    // ==========================================================
    // Descrambler with lock acquisition and hold timer.
    // ==========================================================
    logic [ferx_pkg::LFSR_W-1:0] lfsr_r, lfsr_nxt;
    logic lock_r, lock_nxt;
    logic [ferx_pkg::ACQ_CNT_W-1:0] acq_r, acq_nxt;
    logic [ferx_pkg::RUN_CNT_W-1:0] run_r, run_nxt;
    logic [ferx_pkg::HOLD_W-1:0] hold_r, hold_nxt;
    logic key_bit;
    logic plain_bit;
    logic bit_ok;

    assign key_bit = ferx_key(lfsr_r);

    // While hunting, the register is loaded open loop with the inverted line bits,
    // since idle plain data is all ones; lock follows a long run of correct forecasts.
    always_comb begin
        lfsr_nxt = lfsr_r;
        lock_nxt = lock_r;
        acq_nxt = acq_r;
        run_nxt = run_r;
        hold_nxt = hold_r;
        plain_bit = nrz ^ key_bit;
        if (!sig_det_r) begin
            lock_nxt = 1'b0;
            acq_nxt = '0;
            run_nxt = '0;
        end else if (!lock_r) begin
            lfsr_nxt = {lfsr_r[ferx_pkg::LFSR_W-2:0], ~nrz};
            if (~nrz == key_bit) begin
                if (acq_r == ferx_pkg::ACQ_CNT_W'(ferx_pkg::LOCK_BITS - 1)) begin
                    lock_nxt = 1'b1;
                    hold_nxt = ferx_pkg::HOLD_W'(HOLD_CYCLES - 1);
                    acq_nxt = '0;
                end else begin
                    acq_nxt = acq_r + 1'b1;
                end
            end else begin
                acq_nxt = '0;
            end
        end else begin
            lfsr_nxt = {lfsr_r[ferx_pkg::LFSR_W-2:0], key_bit};
            run_nxt = plain_bit ? run_r + 1'b1 : '0;
            if (plain_bit && run_r == ferx_pkg::RUN_CNT_W'(ferx_pkg::IDLE_RUN_BITS - 1)) begin
                hold_nxt = ferx_pkg::HOLD_W'(HOLD_CYCLES - 1);
                run_nxt = '0;
            end else if (hold_r == '0) begin
                lock_nxt = 1'b0;
                lfsr_nxt = '0;
                run_nxt = '0;
            end else begin
                hold_nxt = hold_r - 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lfsr_r <= '0;
            lock_r <= 1'b0;
            acq_r <= '0;
            run_r <= '0;
            hold_r <= '0;
        end else if (ce) begin
            lfsr_r <= lfsr_nxt;
            lock_r <= lock_nxt;
            acq_r <= acq_nxt;
            run_r <= run_nxt;
            hold_r <= hold_nxt;
        end
    end

    // ==========================================================
    // Serial to parallel, alignment and code-group decoding.
    // ==========================================================
    ferx_pkg::ferx_fr_t st_r, st_nxt;
    logic [ferx_pkg::SR_W-1:0] sr_r, sr_nxt;
    logic [2:0] phase_r, phase_nxt;
    logic [4:0] held_r, held_nxt;
    logic held_k_r, held_k_nxt;
    logic [3:0] rxd_r, rxd_nxt;
    logic dv_r, dv_nxt;
    logic er_r, er_nxt;
    logic stb_r, stb_nxt;
    logic in_bit;
    logic in_ok;
    logic [4:0] grp;
    logic [4:0] dec;

    // In bypass the NRZ bits reach the aligner directly.
    assign in_bit = desc_bypass ? nrz : plain_bit;
    assign in_ok = sig_det_r && (desc_bypass || lock_r);
    assign bit_ok = in_ok;

    // The held group is emitted one group late so the start pair yields two nibbles.
    always_comb begin
        st_nxt = st_r;
        sr_nxt = {sr_r[ferx_pkg::SR_W-2:0], in_bit};
        phase_nxt = phase_r + 1'b1;
        held_nxt = held_r;
        held_k_nxt = held_k_r;
        rxd_nxt = rxd_r;
        dv_nxt = dv_r;
        er_nxt = 1'b0;
        stb_nxt = 1'b0;
        grp = sr_nxt[4:0];
        dec = ferx_decode(held_r);
        if (!bit_ok) begin
            st_nxt = ferx_pkg::FR_HUNT;
            sr_nxt = '0;
            phase_nxt = '0;
            dv_nxt = 1'b0;
        end else begin
            case (st_r)
                ferx_pkg::FR_HUNT: begin
                    if (sr_nxt == {ferx_pkg::CG_IDLE_PAIR, ferx_pkg::CG_JK_PAIR}) begin
                        st_nxt = ferx_pkg::FR_DATA;
                        phase_nxt = '0;
                        held_nxt = ferx_pkg::CG_K;
                        held_k_nxt = 1'b1;
                        rxd_nxt = ferx_pkg::NIB_PREAMBLE;
                        dv_nxt = 1'b1;
                        stb_nxt = 1'b1;
                    end
                end
                ferx_pkg::FR_DATA: begin
                    if (phase_r == ferx_pkg::LAST_PHASE) begin
                        phase_nxt = '0;
                        if ((held_r == ferx_pkg::CG_T && grp == ferx_pkg::CG_R)
                            || (held_r == ferx_pkg::CG_IDLE && grp == ferx_pkg::CG_IDLE)) begin
                            st_nxt = ferx_pkg::FR_HUNT;
                            dv_nxt = 1'b0;
                        end else begin
                            stb_nxt = 1'b1;
                            dv_nxt = 1'b1;
                            if (held_k_r) begin
                                rxd_nxt = ferx_pkg::NIB_PREAMBLE;
                            end else begin
                                rxd_nxt = dec[3:0];
                                er_nxt = ~dec[4];
                            end
                            held_nxt = grp;
                            held_k_nxt = 1'b0;
                        end
                    end
                end
                default: st_nxt = ferx_pkg::FR_HUNT;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= ferx_pkg::FR_HUNT;
            sr_r <= '0;
            phase_r <= '0;
            held_r <= '0;
            held_k_r <= 1'b0;
            rxd_r <= '0;
            dv_r <= 1'b0;
            er_r <= 1'b0;
            stb_r <= 1'b0;
        end else if (ce) begin
            st_r <= st_nxt;
            sr_r <= sr_nxt;
            phase_r <= phase_nxt;
            held_r <= held_nxt;
            held_k_r <= held_k_nxt;
            rxd_r <= rxd_nxt;
            dv_r <= dv_nxt;
            er_r <= er_nxt;
            stb_r <= stb_nxt;
        end
    end

    // Status and receive outputs are registered; nib_stb is also gated by ce.
    assign sig_det = sig_det_r;
    assign desc_lock = lock_r;
    assign aligned = (st_r == ferx_pkg::FR_DATA);
    assign nib_stb = stb_r & ce;
    assign rx_dv = dv_r;
    assign rx_er = er_r;
    assign rxd = rxd_r;

endmodule : ferx_rx_pcs

// >>> ferx_rx_pcs_monitor.sv
`timescale 1ns/1ns
// ==========================================
// Port checker for the receive path.
// ==========================================
module ferx_rx_pcs_monitor #(
    parameter int HOLD_CYCLES = ferx_pkg::HOLD_CYCLES
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic energy_det,
    input wire logic sig_det,
    input wire logic desc_lock,
    input wire logic aligned,
    input wire logic nib_stb,
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [3:0] rxd
);
    logic [13:0] lk_cnt_r, lk_cnt_nxt;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    // Locked bit times; it saturates so a long lock never wraps into a short one.
    always_comb begin
        lk_cnt_nxt = lk_cnt_r;
        if (ce) begin
            lk_cnt_nxt = desc_lock ? lk_cnt_r + 14'(lk_cnt_r != 14'h3fff) : 14'h0000;
        end
    end
    // Register stage of the helper counter.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lk_cnt_r <= 14'h0000;
        end else begin
            lk_cnt_r <= lk_cnt_nxt;
        end
    end
    // A packet opens with two preamble nibbles five bit times apart.
    sequence pre_nib;
        nib_stb && rxd == ferx_pkg::NIB_PREAMBLE;
    endsequence
    sig_qual_a: assert property ($rose(sig_det) |-> $past(energy_det, 23))
        else $error("signal detect rose on a short burst");
    sig_drop_a: assert property (ce && !energy_det |=> !sig_det)
        else $error("signal detect held without energy");
    loss_clear_a: assert property (ce && !sig_det |=> !desc_lock && !aligned)
        else $error("lock or alignment kept without signal");
    lock_acq_a: assert property ($rose(desc_lock) |-> $past(sig_det, 60))
        else $error("lock gained too soon");
    hold_min_a: assert property ($fell(desc_lock) && sig_det |->
        int'(lk_cnt_r) >= HOLD_CYCLES - 2)
        else $error("lock dropped before the hold time");
    nib_gap_a: assert property (nib_stb |=> (!nib_stb) [*4])
        else $error("nibbles closer than one group");
    pre_pair_a: assert property ($rose(rx_dv) |-> pre_nib ##5 pre_nib)
        else $error("preamble pair missing");
    err_nib_a: assert property (nib_stb && rx_er |-> rxd == ferx_pkg::NIB_ERROR && rx_dv)
        else $error("error nibble wrong");
    dv_aligned_a: assert property (rx_dv |-> aligned)
        else $error("data valid without alignment");
    nib_in_pkt_a: assert property (nib_stb |-> rx_dv)
        else $error("nibble outside a packet");
endmodule : ferx_rx_pcs_monitor

bind ferx_rx_pcs ferx_rx_pcs_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.mclk, .rst_n, .ce,
    .energy_det, .sig_det, .desc_lock, .aligned, .nib_stb, .rx_dv, .rx_er, .rxd);

// >>> tb.sv
`timescale 1ns/1ns
// ==========================================
// Self-checking bench for the receive path.
// ==========================================
module tb;
    localparam int HOLD_P = 300;
    localparam logic [4:0] CG [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
        5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic energy_det = 1'b0;
    logic desc_bypass = 1'b0;
    logic line_bit = 1'b1;
    logic scr_on = 1'b1;
    logic ce = 1'b1;
    logic [1:0] sym_lvl;
    logic sig_det, desc_lock, aligned, nib_stb, rx_dv, rx_er;
    logic [3:0] rxd;
    logic [6:0] got [$];
    int errors = 0;
    int comparisons = 0;
    // Bit clock; the hold count is shortened to keep the run brief.
    always #50 mclk = ~mclk;
    ferx_line_model u_line (.mclk, .ce, .plain_bit(line_bit), .scr_on, .sym_lvl);
    ferx_rx_pcs #(.HOLD_CYCLES(HOLD_P)) uut (.mclk, .rst_n, .ce, .sym_lvl, .energy_det,
        .desc_bypass, .sig_det, .desc_lock, .aligned, .nib_stb, .rx_dv, .rx_er, .rxd);
    // Nibbles are taken on the falling edge, clear of the edge that launches them.
    always @(negedge mclk) begin
        if (nib_stb === 1'b1) begin
            got.push_back({aligned, rx_dv, rx_er, rxd});
        end
    end
    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // A bound that runs out is a mismatch and ends the run.
    task automatic give_up(input int k, input int lim);
        if (k >= lim) begin
            errors++;
            print_verdict();
        end
    endtask : give_up
    task automatic send_bit(input logic b);
        @(negedge mclk);
        line_bit <= b;
    endtask : send_bit
    task automatic send_grp(input logic [4:0] g);
        for (int i = 4; i >= 0; i--) send_bit(g[i]);
    endtask : send_grp
    // Link-pulse-like bursts must not qualify; steady energy must.
    task automatic t_sig_det;
        int k;
        repeat (4) begin
            energy_det <= 1'b1;
            repeat (12) send_bit(1'b1);
            check("sig_det burst", 8'h00, {7'h00, sig_det});
            energy_det <= 1'b0;
            repeat (20) send_bit(1'b1);
        end
        energy_det <= 1'b1;
        for (k = 0; k < 60 && sig_det !== 1'b1; k++) send_bit(1'b1);
        give_up(k, 60);
        check("sig_det delay ok", 8'h01, 8'(k >= 23 && k <= 28));
    endtask : t_sig_det
    // Scrambled idle brings lock only after twelve whole idle groups.
    task automatic t_lock;
        int k;
        for (k = 0; k < 200 && desc_lock !== 1'b1; k++) send_bit(1'b1);
        give_up(k, 200);
        check("lock bits ok", 8'h01, 8'(k >= 60 && k <= 110));
    endtask : t_lock
    // A low enable freezes all state, so energy loss meanwhile must go unseen.
    task automatic t_freeze;
        ce <= 1'b0;
        energy_det <= 1'b0;
        repeat (10) send_bit(1'b1);
        check("sig_det frozen", 8'h01, {7'h00, sig_det});
        check("lock frozen", 8'h01, {7'h00, desc_lock});
        ce <= 1'b1;
        energy_det <= 1'b1;
    endtask : t_freeze
    // Idles, J/K, all sixteen data groups, a halt inside data, then T/R.
    task automatic t_packet;
        logic [4:0] pkt [$];
        logic [7:0] exp;
        pkt = {5'h1f, 5'h1f, 5'h18, 5'h11};
        for (int n = 0; n < 16; n++) pkt.push_back(CG[n]);
        pkt = {pkt, 5'h04, 5'h0d, 5'h07, 5'h1f, 5'h1f, 5'h1f};
        got.delete();
        foreach (pkt[i]) send_grp(pkt[i]);
        check("nibble count", 8'h13, 8'(got.size()));
        foreach (got[n]) begin
            exp = (n < 2) ? 8'h65 : (n < 18) ? 8'(8'h60 + n - 2) : 8'h7e;
            check("nibble", exp, {1'b0, got[n]});
        end
        check("rx_dv after end", 8'h00, {7'h00, rx_dv});
        check("aligned after end", 8'h00, {7'h00, aligned});
    endtask : t_packet
    // Idle keeps lock; idle-free traffic lets the timer expire; idle relocks.
    task automatic t_hold;
        int k;
        logic lost = 1'b0;
        for (k = 0; k < 3 * HOLD_P; k++) begin
            send_bit(1'b1);
            lost |= !desc_lock;
        end
        check("lock kept", 8'h00, {7'h00, lost});
        for (k = 0; k < 2 * HOLD_P && desc_lock === 1'b1; k++) send_bit(k % 5 == 0);
        give_up(k, 2 * HOLD_P);
        check("hold expiry ok", 8'h01, 8'(k >= HOLD_P - 60 && k <= HOLD_P + 5));
        for (k = 0; k < 200 && desc_lock !== 1'b1; k++) send_bit(1'b1);
        give_up(k, 200);
        energy_det <= 1'b0;
        repeat (3) send_bit(1'b1);
        check("sig_det lost", 8'h00, {7'h00, sig_det});
        check("lock lost", 8'h00, {7'h00, desc_lock});
    endtask : t_hold
    // Bypassed descrambler: plain groups still frame and decode without lock.
    task automatic t_bypass;
        int k;
        energy_det <= 1'b1;
        desc_bypass <= 1'b1;
        scr_on <= 1'b0;
        for (k = 0; k < 60 && sig_det !== 1'b1; k++) send_bit(1'b1);
        give_up(k, 60);
        t_packet();
    endtask : t_bypass
    // Reset for three clocks, then the scenarios in order.
    initial begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rst_n <= 1'b1;
        t_sig_det();
        t_lock();
        t_freeze();
        t_packet();
        t_hold();
        t_bypass();
        print_verdict();
    end
endmodule : tb
